// file: src/msc_system_configuration.v
// Behaviour
// - All resets restore configuration defaults
// - Configuration joins periodic checksum self-check
// - Bit 29 enables voltage converter
// - Bit 28 enables current B converter
// - Bit 27 enables current A converter
// - Bit 26 voltage gain: 0 x4, 1 x1
// - Bits 25:24 current B gain code
// - Bits 23:22 current A gain code
// - Bits 21:20 converter clock select
// - Bit 19 metering clock select
// - Bits 18:16 fine reference TC trim
// - Bits 15:14 coarse reference TC trim
// - Bit 13 shorts voltage amplifier
// - Bit 12 shorts current amplifier
// - Bits 11:7 oscillator trim
// - Bit 6 boosts oscillator by 1.2
// - Sum every 5 ms, flag non-ones
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`include "msc_defs.vh"
module msc_system_configuration #(
   parameter CHK_PERIOD = `MSC_CHK_PERIOD_CYC
) (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Other reset sources, one-cycle requests
   input wire rx_reset_req,
   // Sum of the other checked registers
   input wire [31:0] other_checked_sum,
   // Analog controls
   output reg voltage_converter_enable,
   output reg current_b_converter_enable,
   output reg current_a_converter_enable,
   output reg voltage_analog_gain_select,
   output reg [1:0] current_b_analog_gain,
   output reg [1:0] current_a_analog_gain,
   output reg [1:0] converter_clock_select,
   output reg metering_clock_select,
   output reg [2:0] reference_fine_tc_trim,
   output reg [1:0] reference_coarse_tc_trim,
   output reg voltage_amp_short,
   output reg current_amp_short,
   output reg [4:0] oscillator_trim,
   output reg oscillator_boost_60hz,
   // Checksum result
   output reg checksum_error_flag,
   output reg checksum_nmi
);

   // APB answer states, one-hot
   localparam APB_IDLE = 2'b01;
   localparam APB_RESP = 2'b10;
   // Checksum phases, one-hot
   localparam CK_COUNT = 3'b001;
   localparam CK_ADD = 3'b010;
   localparam CK_JUDGE = 3'b100;

   // Configuration, checksum, software reset and APB answer state
   reg [31:0] sys_cfg_reg;
   reg [31:0] sys_cfg_next;
   reg [31:0] chk_sum_reg;
   reg [31:0] chk_sum_next;
   reg [31:0] period_cnt_reg;
   reg [31:0] period_cnt_next;
   reg [31:0] total_sum_reg;
   reg [31:0] total_sum_next;
   reg sw_reset_reg;
   reg sw_reset_next;
   reg [1:0] apb_state_reg;
   reg [1:0] apb_state_next;
   reg [2:0] ck_state_reg;
   reg [2:0] ck_state_next;
   // Read word staged one cycle before pready; next checksum flag and NMI
   reg [31:0] rd_word_next;
   reg err_flag_next;
   reg nmi_next;
   // Next values of the analog controls
   reg voltage_converter_enable_next;
   reg current_b_converter_enable_next;
   reg current_a_converter_enable_next;
   reg voltage_analog_gain_select_next;
   reg [1:0] current_b_analog_gain_next;
   reg [1:0] current_a_analog_gain_next;
   reg [1:0] converter_clock_select_next;
   reg metering_clock_select_next;
   reg [2:0] reference_fine_tc_trim_next;
   reg [1:0] reference_coarse_tc_trim_next;
   reg voltage_amp_short_next;
   reg current_amp_short_next;
   reg [4:0] oscillator_trim_next;
   reg oscillator_boost_60hz_next;
   // Bus strobes, reset sources and check period end
   wire acc;
   wire wr;
   wire resp_start;
   wire soft_clear;
   wire period_done;

   function is_mapped;
      input [11:0] a;
      begin
         is_mapped = (a == `MSC_ADDR_SYSCFG) || (a == `MSC_ADDR_CHK_SUM) ||
            (a == `MSC_ADDR_CHK_STS) || (a == `MSC_ADDR_CTRL);
      end
   endfunction

   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;
   // Answer launches in the first access cycle
   assign resp_start = (apb_state_reg == APB_IDLE) && psel && penable;
   assign soft_clear = rx_reset_req || sw_reset_reg;
   assign period_done = (period_cnt_reg == CHK_PERIOD - 1);

   // Bits 5:0 are held elsewhere, so they stay zero here
   always @* begin
      sys_cfg_next = sys_cfg_reg;
      if (soft_clear) begin
         sys_cfg_next = `MSC_SYSCFG_RESET;
      end else if (wr && paddr == `MSC_ADDR_SYSCFG) begin
         // bits 31:30 stored as written, kept zero by software
         sys_cfg_next = pwdata & `MSC_SYSCFG_MASK;
      end
   end

   // APB answer state
   always @* begin
      apb_state_next = apb_state_reg;
      case (apb_state_reg)
         APB_IDLE: begin
            // Setup cycles leave the state alone
            if (psel && penable) begin
               apb_state_next = APB_RESP;
            end
         end
         APB_RESP: begin
            // Back to idle so pready stands for one cycle only
            apb_state_next = APB_IDLE;
         end
         default: begin
            apb_state_next = APB_IDLE;
         end
      endcase
   end

   // Read data chosen in the first access cycle, held until the next read
   always @* begin
      rd_word_next = prdata;
      if (resp_start && !pwrite) begin
         case (paddr)
            `MSC_ADDR_SYSCFG: begin
               rd_word_next = sys_cfg_reg;
            end
            `MSC_ADDR_CHK_SUM: begin
               rd_word_next = chk_sum_reg;
            end
            `MSC_ADDR_CHK_STS: begin
               rd_word_next = 32'h00000000;
               rd_word_next[`MSC_BIT_STS_ERR] = checksum_error_flag;
            end
            default: begin
               rd_word_next = 32'h00000000;
            end
         endcase
      end
   end

   // Checksum register and software reset request
   always @* begin
      chk_sum_next = chk_sum_reg;
      sw_reset_next = 1'b0;
      if (soft_clear) begin
         chk_sum_next = 32'h00000000;
      end else if (wr && paddr == `MSC_ADDR_CHK_SUM) begin
         chk_sum_next = pwdata;
      end
      // Software reset lasts one cycle; the write itself is not stored
      if (wr && paddr == `MSC_ADDR_CTRL) begin
         sw_reset_next = pwdata[`MSC_BIT_SWRST];
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_cfg_reg <= `MSC_SYSCFG_RESET;
         chk_sum_reg <= 32'h00000000;
         sw_reset_reg <= 1'b0;
         apb_state_reg <= APB_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         sys_cfg_reg <= sys_cfg_next;
         chk_sum_reg <= chk_sum_next;
         sw_reset_reg <= sw_reset_next;
         apb_state_reg <= apb_state_next;
         // One wait state: pready stands in the second access cycle
         pready <= (apb_state_next == APB_RESP);
         // Unmapped offsets answer with an error and read zero
         pslverr <= resp_start && !is_mapped(paddr);
         prdata <= rd_word_next;
      end
   end

   // Checksum split over three cycles so no cycle holds more than one 32-bit carry chain
   always @* begin
      ck_state_next = ck_state_reg;
      total_sum_next = total_sum_reg;
      err_flag_next = checksum_error_flag;
      nmi_next = 1'b0;
      case (ck_state_reg)
         CK_COUNT: begin
            if (period_done) begin
               total_sum_next = chk_sum_reg + sys_cfg_reg;
               ck_state_next = CK_ADD;
            end
         end
         CK_ADD: begin
            // A write after the first step is seen at the next check
            total_sum_next = total_sum_reg + other_checked_sum;
            ck_state_next = CK_JUDGE;
         end
         CK_JUDGE: begin
            err_flag_next = (total_sum_reg != `MSC_CHK_GOOD);
            nmi_next = (total_sum_reg != `MSC_CHK_GOOD);
            ck_state_next = CK_COUNT;
         end
         default: begin
            ck_state_next = CK_COUNT;
         end
      endcase
   end

   // Period counter runs free; CHK_PERIOD must be at least 3 cycles
   always @* begin
      if (period_done) begin
         period_cnt_next = 32'h00000000;
      end else begin
         period_cnt_next = period_cnt_reg + 32'h00000001;
      end
   end

   // Flag holds until a passing sum
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_cnt_reg <= 32'h00000000;
         total_sum_reg <= 32'h00000000;
         ck_state_reg <= CK_COUNT;
         checksum_error_flag <= 1'b0;
         checksum_nmi <= 1'b0;
      end else begin
         period_cnt_reg <= period_cnt_next;
         total_sum_reg <= total_sum_next;
         ck_state_reg <= ck_state_next;
         checksum_error_flag <= err_flag_next;
         checksum_nmi <= nmi_next;
      end
   end

   // Field split of the next configuration value
   always @* begin
      voltage_converter_enable_next = sys_cfg_next[`MSC_BIT_UEN];
      current_b_converter_enable_next = sys_cfg_next[`MSC_BIT_IBEN];
      current_a_converter_enable_next = sys_cfg_next[`MSC_BIT_IAEN];
      voltage_analog_gain_select_next = sys_cfg_next[`MSC_BIT_VGAIN];
      current_b_analog_gain_next = sys_cfg_next[`MSC_FLD_CURB_GAIN_HI:`MSC_FLD_CURB_GAIN_LO];
      current_a_analog_gain_next = sys_cfg_next[`MSC_FLD_CURA_GAIN_HI:`MSC_FLD_CURA_GAIN_LO];
      // converter clock code; ratio is left to software
      converter_clock_select_next = sys_cfg_next[`MSC_FLD_CONV_CLK_HI:`MSC_FLD_CONV_CLK_LO];
      metering_clock_select_next = sys_cfg_next[`MSC_BIT_METCLK];
      reference_fine_tc_trim_next = sys_cfg_next[`MSC_FLD_FINE_TC_HI:`MSC_FLD_FINE_TC_LO];
      reference_coarse_tc_trim_next = sys_cfg_next[`MSC_FLD_COARSE_TC_HI:`MSC_FLD_COARSE_TC_LO];
      voltage_amp_short_next = sys_cfg_next[`MSC_BIT_USHORT];
      current_amp_short_next = sys_cfg_next[`MSC_BIT_ISHORT];
      oscillator_trim_next = sys_cfg_next[`MSC_FLD_OSC_TRIM_HI:`MSC_FLD_OSC_TRIM_LO];
      oscillator_boost_60hz_next = sys_cfg_next[`MSC_BIT_BOOST];
   end

   // Registered so every output is a flop and follows the register's own edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voltage_converter_enable <= 1'b0;
         current_b_converter_enable <= 1'b0;
         current_a_converter_enable <= 1'b0;
         voltage_analog_gain_select <= 1'b0;
         current_b_analog_gain <= 2'h0;
         current_a_analog_gain <= 2'h0;
         converter_clock_select <= 2'h0;
         metering_clock_select <= 1'b0;
         reference_fine_tc_trim <= 3'h0;
         reference_coarse_tc_trim <= 2'h0;
         voltage_amp_short <= 1'b0;
         current_amp_short <= 1'b0;
         oscillator_trim <= 5'h00;
         oscillator_boost_60hz <= 1'b0;
      end else begin
         voltage_converter_enable <= voltage_converter_enable_next;
         current_b_converter_enable <= current_b_converter_enable_next;
         current_a_converter_enable <= current_a_converter_enable_next;
         voltage_analog_gain_select <= voltage_analog_gain_select_next;
         current_b_analog_gain <= current_b_analog_gain_next;
         current_a_analog_gain <= current_a_analog_gain_next;
         converter_clock_select <= converter_clock_select_next;
         metering_clock_select <= metering_clock_select_next;
         reference_fine_tc_trim <= reference_fine_tc_trim_next;
         reference_coarse_tc_trim <= reference_coarse_tc_trim_next;
         voltage_amp_short <= voltage_amp_short_next;
         current_amp_short <= current_amp_short_next;
         oscillator_trim <= oscillator_trim_next;
         oscillator_boost_60hz <= oscillator_boost_60hz_next;
      end
   end

endmodule // msc_system_configuration

// file: src/msc_defs.vh
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH
`define MSC_ADDR_SYSCFG 12'h180
`define MSC_ADDR_CHK_SUM 12'h184
`define MSC_ADDR_CHK_STS 12'h188
`define MSC_ADDR_CTRL 12'h18C
`define MSC_SYSCFG_RESET 32'h00000000
`define MSC_SYSCFG_MASK 32'hFFFFFFC0
`define MSC_CHK_GOOD 32'hFFFFFFFF
`define MSC_CHK_PERIOD_MS 5
`define MSC_CLK_MHZ 100
`define MSC_CHK_PERIOD_CYC (`MSC_CHK_PERIOD_MS * 1000 * `MSC_CLK_MHZ)
`define MSC_BIT_UEN 29
`define MSC_BIT_IBEN 28
`define MSC_BIT_IAEN 27
`define MSC_BIT_VGAIN 26
`define MSC_FLD_CURB_GAIN_HI 25
`define MSC_FLD_CURB_GAIN_LO 24
`define MSC_FLD_CURA_GAIN_HI 23
`define MSC_FLD_CURA_GAIN_LO 22
`define MSC_FLD_CONV_CLK_HI 21
`define MSC_FLD_CONV_CLK_LO 20
`define MSC_BIT_METCLK 19
`define MSC_FLD_FINE_TC_HI 18
`define MSC_FLD_FINE_TC_LO 16
`define MSC_FLD_COARSE_TC_HI 15
`define MSC_FLD_COARSE_TC_LO 14
`define MSC_BIT_USHORT 13
`define MSC_BIT_ISHORT 12
`define MSC_FLD_OSC_TRIM_HI 11
`define MSC_FLD_OSC_TRIM_LO 7
`define MSC_BIT_BOOST 6
`define MSC_BIT_SWRST 0
`define MSC_BIT_STS_ERR 0
`endif

// file: verif/msc_props.sv
`timescale 1ns/100ps
module msc_props (
   // APB
   input wire pclk, input wire presetn, input wire psel, input wire penable, input wire pwrite,
   input wire [11:0] paddr, input wire [31:0] pwdata, input wire [31:0] prdata,
   input wire pready, input wire pslverr,
   // Controls and status
   input wire rx_reset_req, input wire voltage_converter_enable, input wire [1:0] current_b_analog_gain,
   input wire [4:0] oscillator_trim, input wire oscillator_boost_60hz,
   input wire checksum_error_flag, input wire checksum_nmi
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Writes land at the edge where pready is high
   wire wr_cfg = pready && pwrite && paddr == 12'h180;
   a_ready_wait: assert property (
      $rose(penable) && psel |=> pready) else $error("ready late");
   a_ready_pulse: assert property (
      pready |=> !pready) else $error("ready held");
   a_bad_addr: assert property (
      pready && !pwrite && paddr > 12'h18C |-> pslverr && prdata == 32'h0) else $error("unmapped ok");
   a_volt_en: assert property (
      wr_cfg |=> voltage_converter_enable == $past(pwdata[29])) else $error("enable wrong");
   a_gain_b: assert property (
      wr_cfg |=> current_b_analog_gain == $past(pwdata[25:24])) else $error("gain wrong");
   a_osc_trim: assert property (
      wr_cfg |=> {oscillator_trim, oscillator_boost_60hz} == $past(pwdata[11:6])) else $error("trim wrong");
   a_rx_clear: assert property (
      rx_reset_req |=> !voltage_converter_enable && oscillator_trim == 5'h00) else $error("rx not clear");
   a_read_back: assert property (
      pready && !pwrite && paddr == 12'h180 |-> prdata[29] == voltage_converter_enable && prdata[5:0] == 6'h00)
      else $error("readback wrong");
   a_nmi_flag: assert property (
      $rose(checksum_error_flag) |-> checksum_nmi ##1 !checksum_nmi) else $error("nmi wrong");
endmodule // msc_props
bind msc_system_configuration msc_props u_props (.*);

// file: verif/tb_msc_system_configuration.sv
`timescale 1ns/100ps
module tb_msc_system_configuration;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_reset_req = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, other_checked_sum = 0, prdata, rd, c, s;
   logic pready, pslverr, er, voltage_converter_enable, current_b_converter_enable, current_a_converter_enable;
   logic voltage_analog_gain_select, metering_clock_select, voltage_amp_short, current_amp_short;
   logic oscillator_boost_60hz, checksum_error_flag, checksum_nmi;
   logic [1:0] current_b_analog_gain, current_a_analog_gain, converter_clock_select, reference_coarse_tc_trim;
   logic [2:0] reference_fine_tc_trim;
   logic [4:0] oscillator_trim;
   int n_fail = 0, tests_run = 0, i;
   // Model of the stored configuration and checksum words
   logic [31:0] m_cfg = 0, m_chk = 0;
   wire [23:0] f = {voltage_converter_enable, current_b_converter_enable, current_a_converter_enable,
      voltage_analog_gain_select, current_b_analog_gain, current_a_analog_gain, converter_clock_select,
      metering_clock_select, reference_fine_tc_trim, reference_coarse_tc_trim, voltage_amp_short,
      current_amp_short, oscillator_trim, oscillator_boost_60hz};
   // Short check period keeps the run brief
   msc_system_configuration #(.CHK_PERIOD(20)) DUT (.*);
   initial forever #5 pclk = ~pclk;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // Only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (w && a == 12'h180) begin
         m_cfg = d & 32'hFFFF_FFC0;
      end
      if (w && a == 12'h184) begin
         m_chk = d;
      end
      if (w && a == 12'h18C && d[0]) begin
         m_cfg = 0;
         m_chk = 0;
      end
   endtask
   task wrap_up;
      $display("checks %0d errors %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      wrap_up;
   end
   initial begin
      c = $urandom(32'h0b8d);
      repeat (3) @(posedge pclk);
      presetn <= 1;
      apb(0, 12'h180, 0);
      chk(rd, 0);
      // Bits 31:30 kept zero by software
      for (i = 0; i < 12; i++) begin
         c = (i < 4) ? i * 32'h0155_5540 : $urandom & 32'h3FFF_FFFF;
         apb(1, 12'h180, c);
         apb(0, 12'h180, 0);
         chk(rd, m_cfg);
         chk({8'h00, f}, {8'h00, m_cfg[29:6]});
      end
      apb(0, 12'h1A0, 0);
      chk({31'h0, er}, 1);
      chk(rd, 0);
      rx_reset_req <= 1;
      @(posedge pclk);
      rx_reset_req <= 0;
      m_cfg = 0;
      m_chk = 0;
      apb(0, 12'h180, 0);
      chk({rd[31:30], f}, {m_cfg[31:30], m_cfg[29:6]});
      apb(1, 12'h180, 32'h3FFF_FFC0);
      apb(1, 12'h18C, 1);
      repeat (2) @(posedge pclk);
      apb(0, 12'h180, 0);
      chk(rd, m_cfg);
      s = $urandom;
      other_checked_sum <= s;
      // Converter clock a quarter of the metering clock, amplifiers not shorted
      c = 32'h2840_0080;
      apb(1, 12'h180, c);
      apb(1, 12'h184, 32'hFFFF_FFFF - s - c);
      repeat (45) @(posedge pclk);
      chk({31'h0, checksum_error_flag}, {31'h0, (m_chk + s + m_cfg) != 32'hFFFF_FFFF});
      apb(1, 12'h180, c ^ 32'h0000_0800);
      repeat (45) @(posedge pclk);
      chk({31'h0, checksum_error_flag}, {31'h0, (m_chk + s + m_cfg) != 32'hFFFF_FFFF});
      apb(0, 12'h188, 0);
      chk(rd, {31'h0, (m_chk + s + m_cfg) != 32'hFFFF_FFFF});
      apb(1, 12'h180, c);
      repeat (45) @(posedge pclk);
      chk({31'h0, checksum_error_flag}, {31'h0, (m_chk + s + m_cfg) != 32'hFFFF_FFFF});
      wrap_up;
   end
endmodule // tb_msc_system_configuration
